// *** logic/fpd_regs.vh ***
// Constants for the dual-channel fan PWM duty controller: offsets, reset values, fields, timing.
// Assumes a 200 MHz system clock and whole-degree unsigned temperature inputs.
`ifndef FPD_REGS_VH
`define FPD_REGS_VH

// Register offsets
`define FPD_CFG_OFF 8'h02
`define FPD_FSD_OFF 8'h08
`define FPD_MAX1_OFF 8'h09
`define FPD_MAX2_OFF 8'h0A
`define FPD_TGT1_OFF 8'h0B
`define FPD_TGT2_OFF 8'h0C
`define FPD_PRES1_OFF 8'h0D
`define FPD_PRES2_OFF 8'h0E
`define FPD_START1_OFF 8'h0F
`define FPD_START2_OFF 8'h10
`define FPD_FSET_OFF 8'h11
`define FPD_RATE_OFF 8'h12
`define FPD_STEP_OFF 8'h13
`define FPD_FREQ_OFF 8'h14

// Reset values
`define FPD_CFG_RST 8'h18
`define FPD_FSD_RST 8'h60
`define FPD_MAX_RST 8'hF0
`define FPD_TGT_RST 8'h00
`define FPD_START_RST 8'h00
`define FPD_FSET_RST 8'h00
`define FPD_RATE_RST 8'hB4
`define FPD_STEP_RST 8'h55
`define FPD_FREQ_RST 8'h40

// Configuration fields
`define FPD_CFG_STANDBY 7
`define FPD_CFG_SOFTRST 6
`define FPD_CFG_TIMEOUT 5
`define FPD_CFG_POL1 4
`define FPD_CFG_POL2 3
`define FPD_CFG_MINDUTY 2
`define FPD_CFG_SRC2 1
`define FPD_CFG_NOSPIN 0

// Fan setup fields
`define FPD_FSET_HYST 7
`define FPD_FSET_STEP2 6
`define FPD_FSET_F1C1 5
`define FPD_FSET_F1C2 4
`define FPD_FSET_F2C1 3
`define FPD_FSET_F2C2 2

// Frequency select fields
`define FPD_FREQ_A 7
`define FPD_FREQ_B 6
`define FPD_FREQ_C 5

// Duty scale and hysteresis
`define FPD_FULL 8'hF0
`define FPD_MIN_CAP 8'h02
`define FPD_INC 8'h02
`define FPD_FAST_MASK 8'hFC
`define FPD_HYST_LO 9'h005
`define FPD_HYST_HI 9'h00A

// Timing
`define FPD_CLK_HZ 200000000
`define FPD_SLOTS 240
`define FPD_PWM_HZ_20 20
`define FPD_PWM_HZ_33 33
`define FPD_PWM_HZ_50 50
`define FPD_PWM_HZ_100 100
`define FPD_PWM_HZ_FAST 35000
`define FPD_RATE_BASE_US 62500
`define FPD_SPINUP_MS 2000

`endif

// *** logic/fpd_fan_pwm_duty_control.v ***
// Dual-channel fan PWM duty controller: registers, automatic duty, rate limiter, PWM outputs.
// Assumes a register port from an external serial front end and converted temperatures.
`timescale 1ns/10ps
`default_nettype none
`include "fpd_regs.vh"

module fpd_fan_pwm_duty_control #(
  parameter [31:0] SLOT_DIV_20 = `FPD_CLK_HZ / (`FPD_PWM_HZ_20 * `FPD_SLOTS),
  parameter [31:0] SLOT_DIV_33 = `FPD_CLK_HZ / (`FPD_PWM_HZ_33 * `FPD_SLOTS),
  parameter [31:0] SLOT_DIV_50 = `FPD_CLK_HZ / (`FPD_PWM_HZ_50 * `FPD_SLOTS),
  parameter [31:0] SLOT_DIV_100 = `FPD_CLK_HZ / (`FPD_PWM_HZ_100 * `FPD_SLOTS),
  parameter [31:0] SLOT_DIV_FAST = `FPD_CLK_HZ / (`FPD_PWM_HZ_FAST * `FPD_SLOTS),
  parameter [31:0] RATE_BASE_CYC = (`FPD_CLK_HZ / 1000000) * `FPD_RATE_BASE_US,
  parameter [31:0] SPINUP_CYC = (`FPD_CLK_HZ / 1000) * `FPD_SPINUP_MS
) (
  input wire clk_sys_i, // System clock
  input wire rst_i, // Asynchronous reset, active high
  input wire [7:0] reg_addr_i, // Register address
  input wire reg_wr_i, // Register write strobe
  input wire [7:0] reg_wdata_i, // Register write data
  output reg [7:0] reg_rdata_o, // Read data, one cycle after address
  input wire [7:0] remote1_temp_i, // Remote thermistor one, degrees C
  input wire [7:0] remote2_temp_i, // Remote thermistor two, degrees C
  input wire [7:0] local_temp_i, // Internal die temperature, degrees C
  output wire fan_drive_one_o, // Fan one pin output value, always low
  output reg fan_drive_one_oe_o, // Fan one pin pulled low when high
  output wire fan_drive_two_o, // Fan two pin output value, always low
  output reg fan_drive_two_oe_o, // Fan two pin pulled low when high
  output wire conversion_halt_o, // Temperature conversions suspended
  output wire bus_timeout_en_o, // Serial bus timeout enabled
  output wire temp2_internal_o // Channel two measures die temperature
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Clip a duty value to full scale
  function [7:0] clip_full;
    input [7:0] v;
    begin
      clip_full = (v > `FPD_FULL) ? `FPD_FULL : v;
    end
  endfunction

  // Step-size code to duty change per temperature step
  function [4:0] step_size;
    input [3:0] code;
    begin
      if (code == 4'hF) begin
        step_size = 5'h1F;
      end else begin
        step_size = {code, 1'b0};
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [7:0] cfg_r;
  reg [7:0] fsd_r;
  reg [7:0] max_r [0:1];
  reg [7:0] tgt_r [0:1];
  reg [7:0] pres_r [0:1];
  reg [7:0] start_r [0:1];
  reg [7:0] fset_r;
  reg [7:0] rate_r;
  reg [7:0] step_r;
  reg [7:0] freq_r;
  reg active_r [0:1];
  reg [6:0] ivl_r [0:1];
  reg [31:0] spin_r [0:1];
  reg [31:0] base_r;
  reg [31:0] presc_r;
  reg [7:0] slot_r;

  wire soft_rst;
  wire base_tick;
  wire fast_pwm;
  wire [7:0] fsd_eff;
  reg [7:0] temp [0:1];
  reg [7:0] chan_duty [0:1];
  reg [7:0] fan_auto [0:1];
  reg fan_mapped [0:1];
  reg [7:0] eff_tgt [0:1];
  reg [7:0] drv [0:1];
  reg step_ok [0:1];
  reg active_nxt [0:1];
  reg [31:0] slot_div;
  reg [7:0] max_eff;
  reg [7:0] diff;
  reg [7:0] steps;
  reg [12:0] sum;
  reg [2:0] code;
  reg sel1;
  reg sel2;
  // Each process owns its loop index so no index has two drivers
  integer i;
  integer m;
  integer j;
  integer k;

  // Writing the reset bit acts at once; the bit itself never stores
  assign soft_rst = reg_wr_i && (reg_addr_i == `FPD_CFG_OFF) && reg_wdata_i[`FPD_CFG_SOFTRST];
  assign conversion_halt_o = cfg_r[`FPD_CFG_STANDBY];
  assign bus_timeout_en_o = ~cfg_r[`FPD_CFG_TIMEOUT];
  assign temp2_internal_o = cfg_r[`FPD_CFG_SRC2];
  assign fast_pwm = freq_r[`FPD_FREQ_C];
  assign fsd_eff = clip_full(fsd_r);
  assign base_tick = (base_r == RATE_BASE_CYC - 32'h1);
  assign fan_drive_one_o = 1'b0;
  assign fan_drive_two_o = 1'b0;

  // ----------------------------------------------------------------
  // Automatic duty per temperature channel
  // ----------------------------------------------------------------
  // Hysteresis keeps the fan at start duty until temperature falls well below start
  always @* begin
    temp[0] = remote1_temp_i;
    temp[1] = cfg_r[`FPD_CFG_SRC2] ? local_temp_i : remote2_temp_i;
    diff = 8'h00;
    steps = 8'h00;
    sum = 13'h0000;
    max_eff = 8'h00;
    for (i = 0; i < 2; i = i + 1) begin
      max_eff = clip_full(max_r[i]);
      if (max_eff < `FPD_MIN_CAP) begin
        max_eff = `FPD_MIN_CAP;
      end
      if (temp[i] >= start_r[i]) begin
        active_nxt[i] = 1'b1;
      end else if (({1'b0, temp[i]} + (fset_r[`FPD_FSET_HYST] ? `FPD_HYST_HI : `FPD_HYST_LO))
                   < {1'b0, start_r[i]}) begin
        active_nxt[i] = 1'b0;
      end else begin
        active_nxt[i] = active_r[i];
      end
      if (temp[i] >= start_r[i]) begin
        diff = temp[i] - start_r[i];
        steps = fset_r[`FPD_FSET_STEP2] ? {1'b0, diff[7:1]} : diff;
        sum = {5'h00, fsd_eff} +
              steps * (i == 0 ? step_size(step_r[7:4]) : step_size(step_r[3:0]));
      end else if (active_r[i] || cfg_r[`FPD_CFG_MINDUTY]) begin
        sum = {5'h00, fsd_eff};
      end else begin
        sum = 13'h0000;
      end
      chan_duty[i] = (sum > {5'h00, max_eff}) ? max_eff : sum[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Channel to output mapping and effective targets
  // ----------------------------------------------------------------
  // Unmapped outputs run from the software target; standby drives toward zero
  always @* begin
    sel1 = 1'b0;
    sel2 = 1'b0;
    for (m = 0; m < 2; m = m + 1) begin
      sel1 = (m == 0) ? fset_r[`FPD_FSET_F1C1] : fset_r[`FPD_FSET_F2C1];
      sel2 = (m == 0) ? fset_r[`FPD_FSET_F1C2] : fset_r[`FPD_FSET_F2C2];
      fan_mapped[m] = sel1 | sel2;
      if (sel1 && sel2) begin
        fan_auto[m] = (chan_duty[0] > chan_duty[1]) ? chan_duty[0] : chan_duty[1];
      end else if (sel1) begin
        fan_auto[m] = chan_duty[0];
      end else begin
        fan_auto[m] = chan_duty[1];
      end
      eff_tgt[m] = cfg_r[`FPD_CFG_STANDBY] ? 8'h00 : tgt_r[m];
    end
  end

  // ----------------------------------------------------------------
  // Rate limiter interval and driven duty
  // ----------------------------------------------------------------
  // Intervals count base ticks so long waits need only a 7-bit counter
  always @* begin
    code = 3'h0;
    for (j = 0; j < 2; j = j + 1) begin
      code = (j == 0) ? rate_r[7:5] : rate_r[4:2];
      if (code == 3'h0) begin
        step_ok[j] = 1'b1;
      end else begin
        step_ok[j] = base_tick && (ivl_r[j] == ((7'h01 << (code - 3'h1)) - 7'h01));
      end
      if (cfg_r[`FPD_CFG_STANDBY]) begin
        drv[j] = 8'h00;
      end else if (spin_r[j] != 32'h0) begin
        drv[j] = `FPD_FULL;
      end else if (fast_pwm) begin
        drv[j] = pres_r[j] & `FPD_FAST_MASK;
      end else begin
        drv[j] = pres_r[j];
      end
    end
  end

  // ----------------------------------------------------------------
  // PWM slot divider selection
  // ----------------------------------------------------------------
  always @* begin
    if (freq_r[`FPD_FREQ_C]) begin
      slot_div = SLOT_DIV_FAST;
    end else if (freq_r[`FPD_FREQ_A] && freq_r[`FPD_FREQ_B]) begin
      slot_div = SLOT_DIV_100;
    end else if (freq_r[`FPD_FREQ_A]) begin
      slot_div = SLOT_DIV_50;
    end else if (freq_r[`FPD_FREQ_B]) begin
      slot_div = SLOT_DIV_33;
    end else begin
      slot_div = SLOT_DIV_20;
    end
  end

  // ----------------------------------------------------------------
  // Register file, limiter and spin-up state
  // ----------------------------------------------------------------
  // Soft reset shares the power-on values so both paths stay in step
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_r <= `FPD_CFG_RST;
      fsd_r <= `FPD_FSD_RST;
      fset_r <= `FPD_FSET_RST;
      rate_r <= `FPD_RATE_RST;
      step_r <= `FPD_STEP_RST;
      freq_r <= `FPD_FREQ_RST;
      base_r <= 32'h0;
      for (k = 0; k < 2; k = k + 1) begin
        max_r[k] <= `FPD_MAX_RST;
        tgt_r[k] <= `FPD_TGT_RST;
        pres_r[k] <= 8'h00;
        start_r[k] <= `FPD_START_RST;
        active_r[k] <= 1'b0;
        ivl_r[k] <= 7'h00;
        spin_r[k] <= 32'h0;
      end
    end else if (soft_rst) begin
      // Taken on the clock, so the asynchronous branch depends on the reset pin alone
      cfg_r <= `FPD_CFG_RST;
      fsd_r <= `FPD_FSD_RST;
      fset_r <= `FPD_FSET_RST;
      rate_r <= `FPD_RATE_RST;
      step_r <= `FPD_STEP_RST;
      freq_r <= `FPD_FREQ_RST;
      base_r <= 32'h0;
      for (k = 0; k < 2; k = k + 1) begin
        max_r[k] <= `FPD_MAX_RST;
        tgt_r[k] <= `FPD_TGT_RST;
        pres_r[k] <= 8'h00;
        start_r[k] <= `FPD_START_RST;
        active_r[k] <= 1'b0;
        ivl_r[k] <= 7'h00;
        spin_r[k] <= 32'h0;
      end
    end else begin
      base_r <= base_tick ? 32'h0 : base_r + 32'h1;
      // Plain register writes
      if (reg_wr_i) begin
        if (reg_addr_i == `FPD_CFG_OFF) begin
          cfg_r <= {reg_wdata_i[7], 1'b0, reg_wdata_i[5:0]};
        end else if (reg_addr_i == `FPD_FSD_OFF) begin
          fsd_r <= reg_wdata_i;
        end else if (reg_addr_i == `FPD_MAX1_OFF) begin
          max_r[0] <= reg_wdata_i;
        end else if (reg_addr_i == `FPD_MAX2_OFF) begin
          max_r[1] <= reg_wdata_i;
        end else if (reg_addr_i == `FPD_START1_OFF) begin
          start_r[0] <= reg_wdata_i;
        end else if (reg_addr_i == `FPD_START2_OFF) begin
          start_r[1] <= reg_wdata_i;
        end else if (reg_addr_i == `FPD_FSET_OFF) begin
          fset_r <= reg_wdata_i;
        end else if (reg_addr_i == `FPD_RATE_OFF) begin
          rate_r <= {reg_wdata_i[7:2], 2'b00};
        end else if (reg_addr_i == `FPD_STEP_OFF) begin
          step_r <= reg_wdata_i;
        end else if (reg_addr_i == `FPD_FREQ_OFF) begin
          freq_r <= {reg_wdata_i[7:5], 5'h00};
        end
      end
      for (k = 0; k < 2; k = k + 1) begin
        active_r[k] <= active_nxt[k];
        // Automatic mode owns the target; manual writes are clipped
        if (fan_mapped[k]) begin
          tgt_r[k] <= fan_auto[k];
        end else if (reg_wr_i && reg_addr_i == (k == 0 ? `FPD_TGT1_OFF : `FPD_TGT2_OFF)) begin
          tgt_r[k] <= clip_full(reg_wdata_i);
        end
        // Interval counter restarts at each granted step
        if (step_ok[k]) begin
          ivl_r[k] <= 7'h00;
        end else if (base_tick) begin
          ivl_r[k] <= ivl_r[k] + 7'h01;
        end
        // Ramp toward target by one increment, snapping when closer
        if (step_ok[k]) begin
          if (rate_r[(k == 0 ? 7 : 4) -: 3] == 3'h0) begin
            pres_r[k] <= eff_tgt[k];
          end else if (pres_r[k] + `FPD_INC <= eff_tgt[k]) begin
            pres_r[k] <= pres_r[k] + `FPD_INC;
          end else if (pres_r[k] >= eff_tgt[k] + `FPD_INC) begin
            pres_r[k] <= pres_r[k] - `FPD_INC;
          end else begin
            pres_r[k] <= eff_tgt[k];
          end
        end
        // Spin-up kicks a stopped fan at full duty unless disabled
        if (spin_r[k] != 32'h0) begin
          spin_r[k] <= cfg_r[`FPD_CFG_STANDBY] ? 32'h0 : spin_r[k] - 32'h1;
        end else if (!cfg_r[`FPD_CFG_NOSPIN] && pres_r[k] == 8'h00 && eff_tgt[k] != 8'h00) begin
          spin_r[k] <= SPINUP_CYC;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // PWM slot timing
  // ----------------------------------------------------------------
  // One shared period keeps both outputs on the same frequency setting
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      presc_r <= 32'h0;
      slot_r <= 8'h00;
    end else if (presc_r >= slot_div - 32'h1) begin
      presc_r <= 32'h0;
      slot_r <= (slot_r == `FPD_FULL - 8'h01) ? 8'h00 : slot_r + 8'h01;
    end else begin
      presc_r <= presc_r + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Open-drain pin drive
  // ----------------------------------------------------------------
  // Registered so the pins never glitch on comparator settling
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      fan_drive_one_oe_o <= 1'b0;
      fan_drive_two_oe_o <= 1'b0;
    end else begin
      fan_drive_one_oe_o <= ~((drv[0] > slot_r) ? cfg_r[`FPD_CFG_POL1]
                                                : ~cfg_r[`FPD_CFG_POL1]);
      fan_drive_two_oe_o <= ~((drv[1] > slot_r) ? cfg_r[`FPD_CFG_POL2]
                                                : ~cfg_r[`FPD_CFG_POL2]);
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Unmapped addresses read zero
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_addr_i == `FPD_CFG_OFF) begin
      reg_rdata_o <= cfg_r;
    end else if (reg_addr_i == `FPD_FSD_OFF) begin
      reg_rdata_o <= fsd_r;
    end else if (reg_addr_i == `FPD_MAX1_OFF) begin
      reg_rdata_o <= max_r[0];
    end else if (reg_addr_i == `FPD_MAX2_OFF) begin
      reg_rdata_o <= max_r[1];
    end else if (reg_addr_i == `FPD_TGT1_OFF) begin
      reg_rdata_o <= tgt_r[0];
    end else if (reg_addr_i == `FPD_TGT2_OFF) begin
      reg_rdata_o <= tgt_r[1];
    end else if (reg_addr_i == `FPD_PRES1_OFF) begin
      reg_rdata_o <= drv[0];
    end else if (reg_addr_i == `FPD_PRES2_OFF) begin
      reg_rdata_o <= drv[1];
    end else if (reg_addr_i == `FPD_START1_OFF) begin
      reg_rdata_o <= start_r[0];
    end else if (reg_addr_i == `FPD_START2_OFF) begin
      reg_rdata_o <= start_r[1];
    end else if (reg_addr_i == `FPD_FSET_OFF) begin
      reg_rdata_o <= fset_r;
    end else if (reg_addr_i == `FPD_RATE_OFF) begin
      reg_rdata_o <= rate_r;
    end else if (reg_addr_i == `FPD_STEP_OFF) begin
      reg_rdata_o <= step_r;
    end else if (reg_addr_i == `FPD_FREQ_OFF) begin
      reg_rdata_o <= freq_r;
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

endmodule // fpd_fan_pwm_duty_control

`default_nettype wire

// *** test/fpd_duty_checker_assertions.sv ***
// Checker for the fan duty controller: config outputs, soft reset, pins, readback.
// Assumes it is bound to the controller top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module fpd_duty_checker (
  input wire logic clk_sys_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic [7:0] reg_addr_i, // Address
  input wire logic reg_wr_i, // Write strobe
  input wire logic [7:0] reg_wdata_i, // Write data
  input wire logic [7:0] reg_rdata_o, // Read data
  input wire logic fan_drive_one_o, // Pin one data
  input wire logic fan_drive_one_oe_o, // Pin one enable
  input wire logic fan_drive_two_o, // Pin two data
  input wire logic fan_drive_two_oe_o, // Pin two enable
  input wire logic conversion_halt_o, // Standby
  input wire logic bus_timeout_en_o, // Timeout enable
  input wire logic temp2_internal_o // Channel two source
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // Plain config writes; a soft reset discards the other bits
  wire cfg_wr = reg_wr_i && reg_addr_i == 8'h02 && !reg_wdata_i[6];
  wire soft_wr = reg_wr_i && reg_addr_i == 8'h02 && reg_wdata_i[6];
  property p_halt; cfg_wr |=> conversion_halt_o == $past(reg_wdata_i[7]); endproperty
  a_halt: assert property (p_halt) else $error("standby output wrong");
  property p_tmo; cfg_wr |=> bus_timeout_en_o != $past(reg_wdata_i[5]); endproperty
  a_tmo: assert property (p_tmo) else $error("timeout enable wrong");
  property p_src; cfg_wr |=> temp2_internal_o == $past(reg_wdata_i[1]); endproperty
  a_src: assert property (p_src) else $error("channel two source wrong");
  property p_soft; soft_wr |=> !conversion_halt_o && bus_timeout_en_o && !temp2_internal_o;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset left config");
  // Standby freezes both pins at their zero-duty level
  property p_stby; conversion_halt_o [*4] |-> $stable(fan_drive_one_oe_o) &&
    $stable(fan_drive_two_oe_o); endproperty
  a_stby: assert property (p_stby) else $error("pin toggles in standby");
  property p_odrain; !fan_drive_one_o && !fan_drive_two_o; endproperty
  a_odrain: assert property (p_odrain) else $error("open drain data not low");
  property p_start; reg_wr_i && reg_addr_i == 8'h0F ##1 !reg_wr_i && reg_addr_i == 8'h0F
    |=> reg_rdata_o == $past(reg_wdata_i, 2); endproperty
  a_start: assert property (p_start) else $error("start temperature readback");
  property p_rate_lo; reg_addr_i == 8'h12 |=> reg_rdata_o[1:0] == 2'h0; endproperty
  a_rate_lo: assert property (p_rate_lo) else $error("rate low bits set");
  property p_freq_lo; reg_addr_i == 8'h14 |=> reg_rdata_o[4:0] == 5'h00; endproperty
  a_freq_lo: assert property (p_freq_lo) else $error("frequency low bits set");
  c_stby: cover property (conversion_halt_o [*4]);
  c_soft: cover property (soft_wr);
  c_pwm: cover property (fan_drive_one_oe_o ##1 !fan_drive_one_oe_o);
endmodule // fpd_duty_checker
`default_nettype wire

// *** test/fpd_fan_model.sv ***
// Fan model: open-drain pin with pull-up, counts high cycles per 240-cycle window.
// Assumes one PWM slot per clock, so one window is one PWM period.
`timescale 1ns/10ps
`default_nettype none
module fpd_fan_model (
  input wire logic clk_i, // Clock
  input wire logic drive_oe_i, // Pin pulled low when high
  output wire logic [7:0] high_slots_o // High cycles in last window
);
  logic [7:0] cnt_r = 8'h00;
  logic [7:0] acc_r = 8'h00;
  logic [7:0] seen_r = 8'h00;
  assign high_slots_o = seen_r;
  // Released pin floats up, so the level is never left unknown
  wire pin = !drive_oe_i;
  // Window totals; any whole window of a steady duty gives the same count
  always @(posedge clk_i) begin
    cnt_r <= (cnt_r == 8'hEF) ? 8'h00 : cnt_r + 8'h01;
    acc_r <= (cnt_r == 8'hEF) ? 8'h00 : acc_r + {7'h00, pin};
    if (cnt_r == 8'hEF) begin
      seen_r <= acc_r + {7'h00, pin};
    end
  end
endmodule // fpd_fan_model
`default_nettype wire

// *** test/fan_pwm_duty_control_tb.sv ***
// Testbench for the fan duty controller: register tasks, table and random scenarios.
// Assumes short limiter, spin-up and slot parameters set at the instance below.
`timescale 1ns/10ps
`default_nettype none
module fan_pwm_duty_control_tb;
  localparam int BASE = 10;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, v, t;
  logic [7:0] r1 = 8'h00, r2 = 8'h00, lt = 8'h00, seen1, seen2;
  logic d1, d2, oe1, oe2, halt, tmo, src;
  int miscompares = 0, checked = 0, n;
  logic [15:0] rst_tab [15] = '{16'h0218, 16'h0860, 16'h09F0, 16'h0AF0, 16'h0B00, 16'h0C00,
    16'h0D00, 16'h0E00, 16'h0F00, 16'h1000, 16'h1100, 16'h12B4, 16'h1355, 16'h1440, 16'h2000};
  // Rows: fan setup, step size, max duty, remote one, remote two, expected target
  logic [47:0] auto_tab [11] = '{48'h2055F01E0000, 48'h2055F0280060, 48'h2055F02D0092,
    48'h2055702D0070, 48'h2055F0250060, 48'h2055F0220000, 48'hA055F02D0092,
    48'hA055F0220060, 48'h6055F02E007E, 48'h20F5F02A009E, 48'h3055F02D0AC4};
  fpd_fan_pwm_duty_control #(.SLOT_DIV_33(32'h1), .SLOT_DIV_50(32'h1),
    .SLOT_DIV_100(32'h1), .SLOT_DIV_FAST(32'h1), .RATE_BASE_CYC(BASE), .SPINUP_CYC(32'h14)) dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .remote1_temp_i(r1),
    .remote2_temp_i(r2), .local_temp_i(lt), .fan_drive_one_o(d1), .fan_drive_one_oe_o(oe1),
    .fan_drive_two_o(d2), .fan_drive_two_oe_o(oe2), .conversion_halt_o(halt),
    .bus_timeout_en_o(tmo), .temp2_internal_o(src));
  fpd_fan_model fan1 (.clk_i(clk_sys_i), .drive_oe_i(oe1), .high_slots_o(seen1));
  fpd_fan_model fan2 (.clk_i(clk_sys_i), .drive_oe_i(oe2), .high_slots_o(seen2));
  always #2.5 clk_sys_i = ~clk_sys_i;
  // Compare and count; every task below starts 1 ns after an edge
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (e !== g) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
  endtask
  // Read data is registered from the address seen at the edge; the write strobe
  // drops here so a write followed by a read never writes stale data to the read address
  task automatic rd(input logic [7:0] a);
    reg_wr_i = 1'b0;
    reg_addr_i = a;
    @(posedge clk_sys_i);
    #1 v = reg_rdata_o;
  endtask
  task automatic idle(input int c);
    reg_wr_i = 1'b0;
    repeat (c) @(posedge clk_sys_i);
    #1;
  endtask
  function automatic logic [7:0] clip(input logic [7:0] x);
    return (x > 8'hF0) ? 8'hF0 : x;
  endfunction
  task automatic regs_at_reset;
    for (int i = 0; i < 15; i++) begin
      rd(rst_tab[i][15:8]);
      chk($sformatf("reg %h", rst_tab[i][15:8]), rst_tab[i][7:0], v);
    end
  endtask
  // Time to reach a new target must lie within one interval of code interval times step count
  task automatic ramp(input logic [7:0] rate, input logic [7:0] tg);
    int iv, ex, c;
    rd(8'h0D);
    iv = BASE << (rate[7:5] - 3'h1);
    ex = iv * (((tg > v) ? (tg - v) : (v - tg)) / 2);
    wr(8'h12, rate);
    wr(8'h0B, tg);
    c = 0;
    do begin
      rd(8'h0D);
      c++;
    end while (v !== tg && c < 2000);
    chk("ramp time in band", 8'h01, {7'h00, (c >= ex - iv) && (c <= ex + iv)});
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog at over fifteen times the expected run length
  initial begin
    #400000;
    miscompares++;
    conclude;
  end
  initial begin
    n = $urandom(61);
    lt = 8'($urandom);
    repeat (10) @(posedge clk_sys_i);
    #1 rst_i = 1'b0;
    wr(8'h0D, 8'h55);
    regs_at_reset;
    $display("test reset values done");
    wr(8'h12, 8'h00);
    for (int i = 0; i < 6; i++) begin
      n = $urandom;
      t = (i == 0) ? 8'hFF : 8'($urandom);
      wr(8'h02, {3'h0, n[0], n[1], 3'h1});
      wr(8'h0B, t);
      wr(8'h0C, ~t);
      idle(500);
      rd(8'h0B);
      chk("target one", clip(t), v);
      rd(8'h0E);
      chk("present two", clip(~t), v);
      chk("fan one level", n[0] ? clip(t) : 8'hF0 - clip(t), seen1);
      chk("fan two level", n[1] ? clip(~t) : 8'hF0 - clip(~t), seen2);
    end
    $display("test manual duty and polarity done");
    wr(8'h02, 8'h19);
    wr(8'h14, 8'h20);
    wr(8'h0B, 8'h12);
    idle(500);
    rd(8'h0D);
    chk("fast present", 8'h10, v);
    chk("fast fan level", 8'h10, seen1);
    wr(8'h14, 8'h40);
    ramp(8'h20, 8'h02);
    ramp(8'h40, 8'h08);
    ramp(8'hE0, 8'h0A);
    $display("test rate limiter done");
    wr(8'h12, 8'h00);
    wr(8'h0B, 8'h80);
    wr(8'h02, 8'hBB);
    idle(10);
    rd(8'h0D);
    chk("standby present", 8'h00, v);
    chk("standby pin enable", 8'h01, {7'h00, oe1});
    wr(8'h02, 8'h18);
    idle(3);
    rd(8'h0D);
    chk("spin-up present", 8'hF0, v);
    idle(30);
    rd(8'h0D);
    chk("after spin-up", 8'h80, v);
    wr(8'h02, 8'h40);
    regs_at_reset;
    $display("test standby spin-up soft reset done");
    wr(8'h0F, 8'h28);
    rd(8'h0F);
    chk("start temperature", 8'h28, v);
    wr(8'h02, 8'h1D);
    wr(8'h11, 8'h20);
    r1 = 8'h1E;
    idle(8);
    rd(8'h0B);
    chk("min duty hold", 8'h60, v);
    wr(8'h02, 8'h19);
    for (int i = 0; i < 11; i++) begin
      wr(8'h11, auto_tab[i][47:40]);
      wr(8'h13, auto_tab[i][39:32]);
      wr(8'h09, auto_tab[i][31:24]);
      r1 = auto_tab[i][23:16];
      r2 = auto_tab[i][15:8];
      idle(8);
      rd(8'h0B);
      chk($sformatf("auto row %0d", i), auto_tab[i][7:0], v);
    end
    // Die source on channel two; remote two is set to give the opposite answer
    wr(8'h02, 8'h1B);
    wr(8'h11, 8'h04);
    r2 = (lt > 8'h0E) ? 8'h00 : 8'hFF;
    idle(8);
    rd(8'h0C);
    chk("die source target", (lt > 8'h0E) ? 8'hF0 : 8'h60 + lt * 8'h0A, v);
    $display("test automatic duty done");
    conclude;
  end
endmodule // fan_pwm_duty_control_tb
bind fpd_fan_pwm_duty_control fpd_duty_checker u_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
  .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .fan_drive_one_o(fan_drive_one_o),
  .fan_drive_one_oe_o(fan_drive_one_oe_o), .fan_drive_two_o(fan_drive_two_o),
  .fan_drive_two_oe_o(fan_drive_two_oe_o), .conversion_halt_o(conversion_halt_o),
  .bus_timeout_en_o(bus_timeout_en_o), .temp2_internal_o(temp2_internal_o));
`default_nettype wire
